// >>> pkg/adc_ext_pkg.sv
package adc_ext_pkg;

   // ----------------------------------------------------------------
   // slot and page map
   // ----------------------------------------------------------------
   localparam logic [2:0] SLOT_STATUS = 3'h7;
   localparam logic [2:0] SLOT_WAIT = 3'h3;
   localparam logic [2:0] SLOT_CTL = 3'h0;
   localparam logic [3:0] PAGE_RESULTS = 4'h5;
   localparam logic [3:0] PAGE_CTL = 4'hD;
   localparam logic [3:0] PAGE_WAIT = 4'hF;

   // ----------------------------------------------------------------
   // status slot fields
   // ----------------------------------------------------------------
   localparam int PAGE_LSB = 0;
   localparam int IRQ_STAT_LSB = 8;
   localparam int IRQ_STAT_W = 8;
   localparam int IRQ_ADC_BIT = 0;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int CTL_CHAN_LSB = 0;
   localparam int CTL_SCAN_BIT = 3;
   localparam int CTL_QUAD_BIT = 4;
   localparam int CTL_PRE_LSB = 5;
   localparam int CTL_SRC_LSB = 8;
   localparam int CTL_IE_BIT = 10;
   localparam int CTL_IT_BIT = 11;
   localparam int CTL_FLAG_BIT = 12;
   localparam int CTL_EN_BIT = 15;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [15:0] WAIT_RESET = 16'h0000;
   localparam int WAIT_WR_LSB = 8;

   // ----------------------------------------------------------------
   // timing: prescaler step and converter clocks per phase
   // ----------------------------------------------------------------
   localparam int PRE_STEP = 8;
   localparam int SAMPLE_TICKS = 2;
   localparam int NIBBLE_TICKS = 1;

   typedef enum logic [1:0] {
      SRC_WRITE = 2'b00,
      SRC_EXTIRQ = 2'b01,
      SRC_TMR2 = 2'b10,
      SRC_TMR0 = 2'b11
   } start_src_e;

   typedef enum logic [1:0] {
      MODE_ONE_X4 = 2'b00,
      MODE_ONE_X1 = 2'b01,
      MODE_FOUR_X1 = 2'b10,
      MODE_FOUR_CONT = 2'b11
   } conv_mode_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_UPPER = 2'b10,
      ST_LOWER = 2'b11
   } conv_state_e;

   // bus request from the core
   typedef struct packed {
      logic rd;
      logic wr;
      logic [2:0] slot;
      logic [15:0] wdata;
   } ext_req_s;

   // whole block state
   typedef struct packed {
      logic [3:0] page;
      logic [IRQ_STAT_W-1:0] irq_stat;
      logic [15:0] wait_map;
      logic [15:0] ctl;
      logic [15:0] run_ctl;
      logic [3:0][7:0] result;
      conv_state_e st;
      logic [8:0] pre_cnt;
      logic [1:0] tick_cnt;
      logic [1:0] chan;
      logic [1:0] pos;
      logic [3:0] upper;
      logic flag;
      logic stretch;
      logic [15:0] rdata;
      logic [2:0] ext_sync;
      logic ext_seen;
   } blk_s;

endpackage : adc_ext_pkg

// >>> verilog/adc_control_ext_banking.sv
`timescale 1ns/100ps
`default_nettype none

module adc_control_ext_banking #(
   parameter int PRE_W = 9
) (
   input wire logic CLK,                          // system clock, 125 MHz
   input wire logic SYS_RST,                      // synchronous reset, high
   input wire adc_ext_pkg::ext_req_s EXT_REQ,     // slot access from core
   input wire logic EXT_WAIT_IN,                  // external wait extension
   output logic EXT_WAIT,                         // stall to core
   output logic [15:0] EXT_RDATA,                 // read data, registered
   output logic EXT_SEL_INTERNAL,                 // slot answered inside
   input wire logic [adc_ext_pkg::IRQ_STAT_W-1:0] IRQ_SOURCES, // other interrupt events
   input wire logic EXTIRQ_ONE_PIN,               // external interrupt one
   input wire logic TMR2_ZERO,                    // timer two timeout pulse
   input wire logic TMR0_ZERO,                    // timer zero timeout pulse
   input wire logic [7:0] SAR_UPPER,              // upper flash nibble in [7:4]
   input wire logic [7:0] SAR_LOWER,              // lower flash nibble in [3:0]
   output logic [1:0] ANALOG_CHAN,                // analog mux select
   output logic ANALOG_SAMPLE,                    // sample and auto-zero
   output logic ANALOG_PWR,                       // converter powered
   output logic ADC_IRQ                           // conversion irq flag level
);

   localparam int IRQ_W_P = adc_ext_pkg::IRQ_STAT_W;

   adc_ext_pkg::blk_s s_r;
   adc_ext_pkg::blk_s s_nxt;

   // next channel with wrap from three to zero
   function automatic logic [1:0] next_chan(input logic [1:0] c);
      next_chan = c + 2'h1;
   endfunction

   logic ext_rise;
   logic start_evt;
   logic pre_tick;
   logic [PRE_W-1:0] pre_max;
   logic access;
   logic wait_hit;
   logic ctl_sel;
   logic [7:0] sample;
   logic last;
   logic ctl_wr;
   logic [15:0] ctl_eff;

   // ----------------------------------------------------------------
   // combinational helpers
   // ----------------------------------------------------------------

   // ext pin edge once the second and third stages agree
   assign ext_rise = s_r.ext_sync[1] & s_r.ext_sync[2] & ~s_r.ext_seen;
   assign access = EXT_REQ.rd | EXT_REQ.wr;
   assign ctl_sel = (s_r.page == adc_ext_pkg::PAGE_CTL) && (EXT_REQ.slot == adc_ext_pkg::SLOT_CTL);

   always_comb begin
      wait_hit = 1'b0;
      if (EXT_REQ.slot != adc_ext_pkg::SLOT_STATUS) begin
         if (EXT_REQ.rd)
            wait_hit = s_r.wait_map[EXT_REQ.slot];
         else if (EXT_REQ.wr)
            wait_hit = s_r.wait_map[adc_ext_pkg::WAIT_WR_LSB + int'(EXT_REQ.slot)];
      end
   end

   // control write in its last access cycle; the value being written is the
   // one that decides source and enable, so a write selecting register start
   // fires itself even when the control slot is mapped for a wait state
   assign ctl_wr = ctl_sel & EXT_REQ.wr & wait_done();
   assign ctl_eff = ctl_wr ? EXT_REQ.wdata : s_r.ctl;

   always_comb begin
      unique case (adc_ext_pkg::start_src_e'(ctl_eff[adc_ext_pkg::CTL_SRC_LSB +: 2]))
         adc_ext_pkg::SRC_WRITE: start_evt = ctl_wr;
         adc_ext_pkg::SRC_EXTIRQ: start_evt = ext_rise;
         adc_ext_pkg::SRC_TMR2: start_evt = TMR2_ZERO;
         adc_ext_pkg::SRC_TMR0: start_evt = TMR0_ZERO;
      endcase
   end

   // a write commits in its last access cycle
   function automatic logic wait_done();
      wait_done = ~(wait_hit & ~s_r.stretch) & ~EXT_WAIT_IN;
   endfunction

   // divide by 8 times (setting + 1)
   assign pre_max = PRE_W'((int'(s_r.run_ctl[adc_ext_pkg::CTL_PRE_LSB +: 3]) + 1) * adc_ext_pkg::PRE_STEP - 1);
   assign pre_tick = (s_r.pre_cnt[PRE_W-1:0] == pre_max);
   assign sample = {s_r.upper, SAR_LOWER[3:0]};

   // last conversion for irq in this mode
   assign last = s_r.pos == 2'h3;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic commit;
      logic [15:0] wv;
      commit = 1'b0;
      wv = 16'h0000;
      s_nxt = s_r;
      s_nxt.ext_sync = {s_r.ext_sync[1:0], EXTIRQ_ONE_PIN};
      if (s_r.ext_sync[1] == s_r.ext_sync[2])
         s_nxt.ext_seen = s_r.ext_sync[2];

      commit = access & wait_done();
      if (access & wait_hit & ~s_r.stretch)
         s_nxt.stretch = 1'b1;
      else if (commit)
         s_nxt.stretch = 1'b0;
      wv = EXT_REQ.wdata;

      // status events; set wins over clear
      if (commit && EXT_REQ.wr && EXT_REQ.slot == adc_ext_pkg::SLOT_STATUS) begin
         s_nxt.irq_stat = s_r.irq_stat & ~wv[adc_ext_pkg::IRQ_STAT_LSB +: IRQ_W_P];
         s_nxt.page = wv[adc_ext_pkg::PAGE_LSB +: 4];
      end

      if (commit && EXT_REQ.wr && s_r.page == adc_ext_pkg::PAGE_WAIT && EXT_REQ.slot == adc_ext_pkg::SLOT_WAIT)
         s_nxt.wait_map = wv;

      if (commit && EXT_REQ.wr && ctl_sel) begin
         s_nxt.ctl = wv;
         s_nxt.flag = 1'b0;
      end

      s_nxt.pre_cnt = (pre_tick || s_r.st == adc_ext_pkg::ST_IDLE) ? 9'h000 : s_r.pre_cnt + 9'h001;
      if (pre_tick) begin
         unique case (s_r.st)
            adc_ext_pkg::ST_IDLE: ;
            adc_ext_pkg::ST_SAMPLE: begin
               s_nxt.tick_cnt = s_r.tick_cnt + 2'h1;
               if (int'(s_r.tick_cnt) == adc_ext_pkg::SAMPLE_TICKS - 1) begin
                  s_nxt.tick_cnt = 2'h0;
                  s_nxt.st = adc_ext_pkg::ST_UPPER;
               end
            end
            adc_ext_pkg::ST_UPPER: begin
               s_nxt.upper = SAR_UPPER[7:4];
               s_nxt.st = adc_ext_pkg::ST_LOWER;
            end
            adc_ext_pkg::ST_LOWER: begin
               if (s_r.run_ctl[adc_ext_pkg::CTL_QUAD_BIT] | s_r.run_ctl[adc_ext_pkg::CTL_SCAN_BIT])
                  s_nxt.result[s_r.chan] = sample;
               else
                  s_nxt.result[s_r.pos] = sample;
               if (s_r.run_ctl[adc_ext_pkg::CTL_IE_BIT] &&
                   (s_r.run_ctl[adc_ext_pkg::CTL_IT_BIT] ? last : (s_r.pos == 2'h0)))
                  s_nxt.flag = 1'b1;
               s_nxt.pos = s_r.pos + 2'h1;
               s_nxt.st = adc_ext_pkg::ST_SAMPLE;
               unique case (adc_ext_pkg::conv_mode_e'(s_r.run_ctl[adc_ext_pkg::CTL_SCAN_BIT +: 2]))
                  adc_ext_pkg::MODE_ONE_X4:
                     if (last) s_nxt.st = adc_ext_pkg::ST_IDLE;
                  adc_ext_pkg::MODE_ONE_X1:
                     s_nxt.st = adc_ext_pkg::ST_IDLE;
                  adc_ext_pkg::MODE_FOUR_X1: begin
                     s_nxt.chan = next_chan(s_r.chan);
                     if (last) s_nxt.st = adc_ext_pkg::ST_IDLE;
                  end
                  adc_ext_pkg::MODE_FOUR_CONT:
                     s_nxt.chan = next_chan(s_r.chan);
               endcase
            end
         endcase
      end

      if (start_evt && ctl_eff[adc_ext_pkg::CTL_EN_BIT]) begin
         s_nxt.run_ctl = ctl_eff;
         s_nxt.chan = s_nxt.run_ctl[adc_ext_pkg::CTL_CHAN_LSB +: 2];
         s_nxt.pos = 2'h0;
         s_nxt.tick_cnt = 2'h0;
         s_nxt.pre_cnt = 9'h000;
         s_nxt.st = adc_ext_pkg::ST_SAMPLE;
      end

      if (!s_nxt.ctl[adc_ext_pkg::CTL_EN_BIT])
         s_nxt.st = adc_ext_pkg::ST_IDLE;

      // converter event into shared status, set after clear
      s_nxt.irq_stat = (s_nxt.irq_stat | IRQ_SOURCES) |
                       (IRQ_W_P'(~s_r.flag & s_nxt.flag) << adc_ext_pkg::IRQ_ADC_BIT);

      // page five results, page 13 control
      s_nxt.rdata = 16'h0000;
      if (EXT_REQ.rd) begin
         if (EXT_REQ.slot == adc_ext_pkg::SLOT_STATUS)
            s_nxt.rdata = {s_r.irq_stat, 4'h0, s_r.page};
         else if (ctl_sel)
            s_nxt.rdata = {s_r.ctl[15:13], s_r.flag, s_r.ctl[11:0]};
         else if (s_r.page == adc_ext_pkg::PAGE_WAIT && EXT_REQ.slot == adc_ext_pkg::SLOT_WAIT)
            s_nxt.rdata = s_r.wait_map;
         else if (s_r.ctl[adc_ext_pkg::CTL_EN_BIT] && s_r.page == adc_ext_pkg::PAGE_RESULTS &&
                  EXT_REQ.slot <= 3'h2)
            s_nxt.rdata = {8'h00, s_r.result[2'(EXT_REQ.slot) + 2'h1]};
         else if (s_r.ctl[adc_ext_pkg::CTL_EN_BIT] && EXT_REQ.slot == 3'h6 &&
                  (s_r.page <= 4'h5 || s_r.page >= 4'h6) && s_r.page != adc_ext_pkg::PAGE_WAIT &&
                  s_r.page != 4'h4)
            s_nxt.rdata = {8'h00, s_r.result[s_r.page <= 4'h3 ? s_r.page[1:0] : 2'h0]};
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         s_r <= '0;
         s_r.ctl <= adc_ext_pkg::CTL_RESET;
         s_r.wait_map <= adc_ext_pkg::WAIT_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign EXT_WAIT = access & ~wait_done();
   assign EXT_RDATA = s_r.rdata;
   assign EXT_SEL_INTERNAL = (EXT_REQ.slot == adc_ext_pkg::SLOT_STATUS) || ctl_sel ||
                             (s_r.page == adc_ext_pkg::PAGE_WAIT && EXT_REQ.slot == adc_ext_pkg::SLOT_WAIT);
   assign ANALOG_CHAN = s_r.chan;
   assign ANALOG_SAMPLE = (s_r.st == adc_ext_pkg::ST_SAMPLE);
   assign ANALOG_PWR = s_r.ctl[adc_ext_pkg::CTL_EN_BIT];
   assign ADC_IRQ = s_r.flag;

endmodule : adc_control_ext_banking

`default_nettype wire

// >>> sim/adc_ext_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// port level checks, attached by bind
module adc_ext_assertions (
   input wire logic CLK, // clock
   input wire logic SYS_RST, // reset
   input wire adc_ext_pkg::ext_req_s EXT_REQ, // access
   input wire logic EXT_WAIT_IN, // ext wait
   input wire logic EXT_WAIT, // stall
   input wire logic [15:0] EXT_RDATA, // read data
   input wire logic EXT_SEL_INTERNAL, // inside
   input wire logic ANALOG_SAMPLE, // sample
   input wire logic ANALOG_PWR, // power
   input wire logic ADC_IRQ // flag
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   logic act;
   logic s7;
   // access present, and access to the status slot
   assign act = EXT_REQ.rd | EXT_REQ.wr;
   assign s7 = act && EXT_REQ.slot == adc_ext_pkg::SLOT_STATUS;
   // fastest prescale still keeps sampling this long
   sequence s_hold;
      ANALOG_SAMPLE [*8];
   endsequence
   a_slot7_no_wait: assert property (s7 && !EXT_WAIT_IN |-> !EXT_WAIT)
      else $error("status slot stalled");
   a_slot7_inside: assert property (s7 |-> EXT_SEL_INTERNAL)
      else $error("status slot not internal");
   a_wait_one: assert property (act && EXT_WAIT && !EXT_WAIT_IN ##1
      $stable(EXT_REQ) && !EXT_WAIT_IN |-> !EXT_WAIT)
      else $error("stretch longer than one cycle");
   a_ext_hold: assert property (act && EXT_WAIT_IN && !s7 |-> EXT_WAIT)
      else $error("wait input ignored");
   a_off_quiet: assert property (!ANALOG_PWR [*2] |-> !ANALOG_SAMPLE)
      else $error("sampling while disabled");
   a_sample_min: assert property (@(posedge CLK) disable iff (SYS_RST || !ANALOG_PWR)
      $rose(ANALOG_SAMPLE) |-> s_hold)
      else $error("sample phase too short");
   a_rdata_idle: assert property (!$past(EXT_REQ.rd && !EXT_WAIT) |-> EXT_RDATA == 16'h0000)
      else $error("read data without read");
   a_irq_powered: assert property ($rose(ADC_IRQ) |-> ANALOG_PWR)
      else $error("flag rose while disabled");
endmodule // adc_ext_assertions
`default_nettype wire

// >>> sim/core_model.sv
`timescale 1ns/100ps
`default_nettype none
// processor side of the slot bus
module core_model (
   input wire logic CLK, // clock
   output adc_ext_pkg::ext_req_s EXT_REQ, // access
   output logic EXT_WAIT_IN, // ext wait
   input wire logic EXT_WAIT, // stall
   input wire logic [15:0] EXT_RDATA // read data
);
   initial begin
      EXT_REQ = '0;
      EXT_WAIT_IN = 1'b0;
   end
   // one access; held until the stall drops, x extra external waits
   task automatic xfer(input logic w, input logic [2:0] s, input logic [15:0] d, input int x,
                       output logic [15:0] q, output int cyc);
      logic stall;
      @(posedge CLK);
      EXT_REQ <= '{rd: !w, wr: w, slot: s, wdata: d};
      EXT_WAIT_IN <= (x > 0);
      cyc = 0;
      do begin
         // stall read mid-cycle, settled for the edge that follows
         @(negedge CLK);
         stall = EXT_WAIT;
         @(posedge CLK);
         cyc++;
         EXT_WAIT_IN <= (cyc < x);
      end while (stall && cyc < 50);
      // released fields flip so stale values never look valid
      EXT_REQ <= '{rd: 1'b0, wr: 1'b0, slot: ~s, wdata: ~d};
      @(negedge CLK);
      q = EXT_RDATA;
   endtask
endmodule // core_model
`default_nettype wire

// >>> sim/tb_adc_control_ext_banking.sv
`timescale 1ns/100ps
`default_nettype none
module tb_adc_control_ext_banking;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   adc_ext_pkg::ext_req_s req;
   logic xw;
   logic ext_wait;
   logic [15:0] rdata;
   logic [7:0] irq_src = 8'h00;
   logic pin = 1'b0;
   logic t2 = 1'b0;
   logic t0 = 1'b0;
   logic [7:0] sar_u = 8'h00;
   logic [7:0] sar_l = 8'h00;
   logic [1:0] chan;
   logic samp;
   logic pwr;
   logic irq;
   int error_cnt = 0;
   int num_checks = 0;
   logic [15:0] q;
   int cyc;
   // 125 MHz
   always #4 clk = ~clk;
   // code follows the channel so a misfiled result shows
   always @(posedge clk) begin
      sar_u <= {2'b10, chan, 4'h0};
      sar_l <= {4'h0, 2'b01, chan};
   end
   adc_control_ext_banking i_dut (.CLK(clk), .SYS_RST(sys_rst), .EXT_REQ(req), .EXT_WAIT_IN(xw),
      .EXT_WAIT(ext_wait), .EXT_RDATA(rdata), .EXT_SEL_INTERNAL(), .IRQ_SOURCES(irq_src),
      .EXTIRQ_ONE_PIN(pin), .TMR2_ZERO(t2), .TMR0_ZERO(t0), .SAR_UPPER(sar_u), .SAR_LOWER(sar_l),
      .ANALOG_CHAN(chan), .ANALOG_SAMPLE(samp), .ANALOG_PWR(pwr), .ADC_IRQ(irq));
   core_model i_core (.CLK(clk), .EXT_REQ(req), .EXT_WAIT_IN(xw), .EXT_WAIT(ext_wait), .EXT_RDATA(rdata));
   function automatic logic [15:0] res(input logic [1:0] c);
      return {8'h00, 2'b10, c, 2'b01, c};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [2:0] s, input logic [15:0] d, input int x);
      i_core.xfer(w, s, d, x, q, cyc);
   endtask
   // bounded wait for a level
   task automatic wt(input int n, input bit on_irq);
      for (int i = 0; i < n && (on_irq ? irq : samp) !== 1'b1; i++) @(posedge clk);
   endtask
   task automatic t_map;
      acc(1'b0, 3'h7, 16'h0000, 0);
      chk(q, 16'h0000);
      acc(1'b1, 3'h7, {12'h000, adc_ext_pkg::PAGE_CTL}, 0);
      acc(1'b0, 3'h0, 16'h0000, 0);
      chk(q, adc_ext_pkg::CTL_RESET);
      acc(1'b0, 3'h7, 16'h0000, 0);
      chk(q, 16'h000D);
      $display("test map done");
   endtask
   task automatic t_wait;
      acc(1'b1, 3'h7, 16'h000F, 0);
      acc(1'b1, 3'h3, 16'h0404, 0);
      acc(1'b0, 3'h3, 16'h0000, 0);
      chk(q, 16'h0404);
      acc(1'b0, 3'h2, 16'h0000, 0);
      chk(cyc[15:0], 16'h0002);
      acc(1'b1, 3'h2, 16'h0000, 0);
      chk(cyc[15:0], 16'h0002);
      acc(1'b0, 3'h1, 16'h0000, 0);
      chk(cyc[15:0], 16'h0001);
      acc(1'b0, 3'h7, 16'h0000, 0);
      chk(cyc[15:0], 16'h0001);
      acc(1'b0, 3'h1, 16'h0000, 2);
      chk(cyc[15:0], 16'h0003);
      acc(1'b1, 3'h3, 16'h0000, 0);
      $display("test wait done");
   endtask
   task automatic t_conv;
      logic [1:0] seq [$];
      logic prev;
      prev = 1'b0;
      acc(1'b1, 3'h7, {12'h000, adc_ext_pkg::PAGE_CTL}, 0);
      acc(1'b1, 3'h0, 16'h8C12, 0);
      for (int i = 0; i < 400 && irq !== 1'b1; i++) begin
         @(posedge clk);
         if (samp === 1'b1 && !prev) seq.push_back(chan);
         prev = samp;
      end
      chk(16'(seq.size()), 16'h0004);
      foreach (seq[i]) chk({14'h0, seq[i]}, {14'h0, 2'(i + 2)});
      chk({15'h0, irq}, 16'h0001);
      acc(1'b1, 3'h7, 16'h0005, 0);
      for (int c = 1; c < 4; c++) begin
         acc(1'b0, 3'(c - 1), 16'h0000, 0);
         chk(q, res(2'(c)));
      end
      acc(1'b1, 3'h7, 16'h0000, 0);
      acc(1'b0, 3'h6, 16'h0000, 0);
      chk(q, res(2'h0));
      @(posedge clk) irq_src <= 8'h08;
      @(posedge clk) irq_src <= 8'h00;
      acc(1'b0, 3'h7, 16'h0000, 0);
      chk(q, 16'h0900);
      acc(1'b1, 3'h7, 16'h0100, 0);
      acc(1'b0, 3'h7, 16'h0000, 0);
      chk(q, 16'h0800);
      $display("test conversion done");
   endtask
   task automatic t_src;
      int n;
      acc(1'b1, 3'h7, {12'h000, adc_ext_pkg::PAGE_CTL}, 0);
      for (int s = 1; s < 4; s++) begin
         acc(1'b1, 3'h0, 16'h8429 | 16'(s << 8), 0);
         chk({15'h0, irq}, 16'h0000);
         repeat (20) @(posedge clk);
         chk({15'h0, samp}, 16'h0000);
         @(posedge clk) begin
            pin <= (s == 1);
            t2 <= (s == 2);
            t0 <= (s == 3);
         end
         @(posedge clk) begin
            t2 <= 1'b0;
            t0 <= 1'b0;
         end
         wt(20, 1'b0);
         chk({14'h0, chan}, 16'h0001);
         // sample phase length at prescale setting one
         n = 0;
         while (samp === 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
         end
         chk(16'(n), 16'(adc_ext_pkg::SAMPLE_TICKS * adc_ext_pkg::PRE_STEP * 2));
         // new channel written mid-run waits for the next start
         acc(1'b1, 3'h0, 16'h842A | 16'(s << 8), 0);
         chk({14'h0, chan}, 16'h0001);
         wt(100, 1'b1);
         chk({15'h0, irq}, 16'h0001);
         pin <= 1'b0;
      end
      $display("test sources done");
   endtask
   task automatic t_abort;
      // continuous scan from channel 0: sixth conversion samples channel 1
      acc(1'b1, 3'h0, 16'h8018, 0);
      repeat (168) @(posedge clk);
      chk({13'h0, samp, chan}, 16'h0005);
      acc(1'b1, 3'h0, 16'h8003, 0);
      repeat (2) @(posedge clk);
      chk({13'h0, samp, chan}, 16'h0007);
      acc(1'b1, 3'h0, 16'h0000, 0);
      chk({14'h0, pwr, samp}, 16'h0000);
      $display("test abort done");
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      t_map;
      t_wait;
      t_conv;
      t_src;
      t_abort;
      finish_test;
   end
   // watchdog well above the expected run
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      finish_test;
   end
endmodule // tb_adc_control_ext_banking
bind adc_control_ext_banking adc_ext_assertions i_chk (.CLK(CLK), .SYS_RST(SYS_RST), .EXT_REQ(EXT_REQ),
   .EXT_WAIT_IN(EXT_WAIT_IN), .EXT_WAIT(EXT_WAIT), .EXT_RDATA(EXT_RDATA), .EXT_SEL_INTERNAL(EXT_SEL_INTERNAL),
   .ANALOG_SAMPLE(ANALOG_SAMPLE), .ANALOG_PWR(ANALOG_PWR), .ADC_IRQ(ADC_IRQ));
`default_nettype wire
